// File: core/touch_report_params.svh
// Constants for the touch report serial framer.
`ifndef TOUCH_REPORT_PARAMS_SVH
`define TOUCH_REPORT_PARAMS_SVH

// ****************************************************************
// Clock and line timing
// ****************************************************************
`define CLK_HZ 100000000
`define BAUD_RATE 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define DATA_BITS 8
`define STOP_BITS 1

// ****************************************************************
// Packet layout
// ****************************************************************
`define PKT_BYTES 10
`define HDR0_BYTE 8'h55
`define HDR1_BYTE 8'h54
`define CHK_SEED 8'hAA

// ****************************************************************
// Report repetition and power-on timing
// ****************************************************************
`define REPORT_PERIOD_US 20000
`define REPORT_PERIOD_CYCLES (`REPORT_PERIOD_US * 100)
`define POWER_ON_US 100000
`define POWER_ON_CYCLES (`POWER_ON_US * 100)

`endif

// File: core/touch_report_pkg.sv
// Types for the touch report serial framer.
package touch_report_pkg;

    typedef struct packed {
        logic [7:0] status;
        logic [15:0] x_coord;
        logic [15:0] y_coord;
        logic [15:0] z_coord;
    } touch_sample_t;

    typedef enum logic [3:0] {
        ST_POWERUP = 4'h1,
        ST_IDLE = 4'h2,
        ST_SEND = 4'h4,
        ST_WAIT = 4'h8
    } framer_state_t;

    typedef struct packed {
        logic [3:0] state;
        logic [3:0] bit_idx;
        logic [15:0] baud_cnt;
        logic [9:0] shift;
        logic busy;
        logic line;
    } uart_state_t;

endpackage

// File: core/serial_char_tx.sv
// Asynchronous serial character transmitter, 8N1.
`timescale 1ns/100ps
`include "touch_report_params.svh"

module serial_char_tx (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic send_valid,
    input wire logic [7:0] send_data,
    output logic send_ready,
    output logic tx_line
);
    import touch_report_pkg::*;

    localparam logic [15:0] BIT_LAST = 16'(`BIT_CYCLES - 1);
    localparam logic [3:0] FRAME_LAST = 4'(`DATA_BITS + `STOP_BITS);

    uart_state_t s_r;
    uart_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!s_r.busy) begin
            if (send_valid) begin
                // Start bit low, data LSB first, stop bit high.
                s_nxt.shift = {1'b1, send_data, 1'b0};
                s_nxt.busy = 1'b1;
                s_nxt.bit_idx = 4'h0;
                s_nxt.baud_cnt = 16'h0000;
                s_nxt.line = 1'b0;
            end
        end else if (s_r.baud_cnt == BIT_LAST) begin
            s_nxt.baud_cnt = 16'h0000;
            if (s_r.bit_idx == FRAME_LAST) begin
                s_nxt.busy = 1'b0;
                s_nxt.line = 1'b1;
            end else begin
                s_nxt.bit_idx = s_r.bit_idx + 4'h1;
                s_nxt.shift = {1'b1, s_r.shift[9:1]};
                s_nxt.line = s_r.shift[1];
            end
        end else begin
            s_nxt.baud_cnt = s_r.baud_cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '{state: 4'h0, bit_idx: 4'h0, baud_cnt: 16'h0000,
                     shift: 10'h3FF, busy: 1'b0, line: 1'b1};
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign send_ready = !s_r.busy;
    assign tx_line = s_r.line;
endmodule

// File: core/touch_report_serial_framer.sv
// Touch report packet framer driving an 8N1 serial line.
`timescale 1ns/100ps
`include "touch_report_params.svh"

// Behaviour
// - Characters go out 9600 baud, eight data bits, one stop, no parity.
// - Line rate is fixed at 9600 baud, no selection.
// - Reports repeat at a constant rate while touched, none when untouched.
// - Ten bytes: 55h, 54h, status, X, Y, Z low/high pairs, checksum.
// - Data-set-ready rises after reset; clear-to-send after power-on delay.
module touch_report_serial_framer #(
    parameter int unsigned REPORT_CYCLES = `REPORT_PERIOD_CYCLES,
    parameter int unsigned POWERUP_CYCLES = `POWER_ON_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic touch_present,
    input wire touch_report_pkg::touch_sample_t sample,
    output logic tx_line,
    output logic dsr_line,
    output logic cts_line,
    output logic report_active
);
    import touch_report_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        framer_state_t state;
        logic [31:0] timer;
        logic [3:0] byte_idx;
        logic [7:0] check;
        touch_sample_t held;
        logic touch_m;
        logic touch_s;
        logic dsr;
        logic cts;
        logic send_valid;
        logic [7:0] send_data;
    } framer_t;

    framer_t f_r;
    framer_t f_nxt;
    logic send_ready;

    localparam logic [3:0] LAST_IDX = 4'(`PKT_BYTES - 1);

    // Picks the packet byte at a given position from the held sample.
    function automatic logic [7:0] pkt_byte(input logic [3:0] idx,
                                            input touch_sample_t smp,
                                            input logic [7:0] chk);
        case (idx)
            4'h0: pkt_byte = `HDR0_BYTE;
            4'h1: pkt_byte = `HDR1_BYTE;
            4'h2: pkt_byte = smp.status;
            4'h3: pkt_byte = smp.x_coord[7:0];
            4'h4: pkt_byte = smp.x_coord[15:8];
            4'h5: pkt_byte = smp.y_coord[7:0];
            4'h6: pkt_byte = smp.y_coord[15:8];
            4'h7: pkt_byte = smp.z_coord[7:0];
            4'h8: pkt_byte = smp.z_coord[15:8];
            default: pkt_byte = chk;
        endcase
    endfunction

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    always_comb begin
        f_nxt = f_r;
        f_nxt.touch_m = touch_present;
        f_nxt.touch_s = f_r.touch_m;
        f_nxt.send_valid = 1'b0;
        f_nxt.dsr = 1'b1;
        if (f_r.timer != 32'h0) begin
            f_nxt.timer = f_r.timer - 32'h1;
        end
        case (f_r.state)
            ST_POWERUP: begin
                if (f_r.timer == 32'h0) begin
                    f_nxt.cts = 1'b1;
                    f_nxt.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (f_r.touch_s) begin
                    f_nxt.held = sample;
                    f_nxt.byte_idx = 4'h0;
                    f_nxt.check = `CHK_SEED;
                    f_nxt.timer = REPORT_CYCLES - 1;
                    f_nxt.state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (send_ready && !f_r.send_valid) begin
                    f_nxt.send_valid = 1'b1;
                    f_nxt.send_data = pkt_byte(f_r.byte_idx, f_r.held, f_r.check);
                    if (f_r.byte_idx != LAST_IDX) begin
                        f_nxt.check = f_r.check + pkt_byte(f_r.byte_idx, f_r.held,
                                                            f_r.check);
                        f_nxt.byte_idx = f_r.byte_idx + 4'h1;
                    end else begin
                        f_nxt.state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // Constant repetition: next report starts REPORT_CYCLES + 1 enabled cycles after the last one started.
                if (f_r.timer == 32'h0) begin
                    f_nxt.state = ST_IDLE;
                end
            end
            default: begin
                f_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            f_r <= '0;
            f_r.state <= ST_POWERUP;
            f_r.timer <= POWERUP_CYCLES;
        end else if (clk_en) begin
            f_r <= f_nxt;
        end
    end

    // ****************************************************************
    // Serial transmitter
    // ****************************************************************
    serial_char_tx u_tx (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .send_valid(f_r.send_valid),
        .send_data(f_r.send_data),
        .send_ready(send_ready),
        .tx_line(tx_line)
    );

    assign dsr_line = f_r.dsr;
    assign cts_line = f_r.cts;
    assign report_active = (f_r.state == ST_SEND) || (f_r.state == ST_WAIT);
endmodule

// File: testbench/host_serial_rx.sv
// Host serial port receiver model for 8N1 characters.
`timescale 1ns/100ps
`include "touch_report_params.svh"
module host_serial_rx (
    input wire logic ref_clk,
    input wire logic line,
    output logic [7:0] rx_byte,
    output int rx_count,
    output logic frame_err
);
    // Samples mid-bit at the fixed rate; a stop slot follows the eighth data bit.
    initial begin
        rx_byte = 8'h00;
        rx_count = 0;
        frame_err = 1'b0;
        forever begin
            @(negedge line);
            repeat (`BIT_CYCLES / 2) @(posedge ref_clk);
            frame_err = frame_err | line;
            for (int i = 0; i < `DATA_BITS; i++) begin
                repeat (`BIT_CYCLES) @(posedge ref_clk);
                rx_byte[i] = line;
            end
            repeat (`BIT_CYCLES) @(posedge ref_clk);
            frame_err = frame_err | !line;
            rx_count = rx_count + 1;
        end
    end
endmodule

// File: testbench/touch_report_serial_framer_checker.sv
// Assertions on the ports of the touch report serial framer.
`timescale 1ns/100ps
`include "touch_report_params.svh"
module touch_report_serial_framer_checker #(
    parameter int unsigned REPORT_CYCLES = 1,
    parameter int unsigned POWERUP_CYCLES = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic touch_present,
    input wire touch_report_pkg::touch_sample_t sample,
    input wire logic tx_line,
    input wire logic dsr_line,
    input wire logic cts_line,
    input wire logic report_active
);
    localparam int BIT = `BIT_CYCLES;
    logic [19:0] low_run_r;
    always_ff @(posedge ref_clk) begin
        if (rst || tx_line) begin
            low_run_r <= '0;
        end else if (clk_en) begin
            low_run_r <= low_run_r + 20'h00001;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_dsr_after_reset: assert property ($fell(rst) && clk_en |=> dsr_line)
        else $error("data set ready missing after reset");
    a_cts_no_report: assert property (!cts_line |-> !report_active)
        else $error("report before clear to send");
    a_cts_holds_high: assert property (cts_line |=> cts_line)
        else $error("clear to send dropped");
    a_idle_line_high: assert property (!report_active |-> tx_line)
        else $error("line active outside a report");
    a_low_run_bits: assert property ($rose(tx_line) |-> low_run_r != 0 && low_run_r % BIT == 0)
        else $error("low run not whole bit times");
    a_start_bit_soon: assert property ($rose(report_active) |-> ##[1:8] !tx_line)
        else $error("no start bit after report start");
    a_untouched_quiet: assert property ((!touch_present && !report_active) [*4] |=> !report_active)
        else $error("report started while untouched");
    c_report: cover property ($rose(report_active));
    c_cts: cover property ($rose(cts_line));
    c_start: cover property ($fell(tx_line));
endmodule
bind touch_report_serial_framer touch_report_serial_framer_checker #(
    .REPORT_CYCLES(REPORT_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES)) chk_u (.ref_clk(ref_clk),
    .rst(rst), .clk_en(clk_en), .touch_present(touch_present), .sample(sample),
    .tx_line(tx_line), .dsr_line(dsr_line), .cts_line(cts_line), .report_active(report_active));

// File: testbench/touch_report_serial_framer_tb_top.sv
// Self-checking testbench for the touch report serial framer.
`timescale 1ns/100ps
`include "touch_report_params.svh"
module touch_report_serial_framer_tb_top;
    import touch_report_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic touch_present = 1'b0;
    touch_sample_t sample = {8'h81, 16'h0FA5, 16'h5A3C, 16'h0000};
    logic tx_line, dsr_line, cts_line, report_active, frame_err;
    logic [7:0] rx_byte;
    logic [7:0] exp_bytes [10];
    int rx_count;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    // The period must exceed one packet of about 1.04M cycles to keep the rate constant.
    touch_report_serial_framer #(.REPORT_CYCLES(1100000), .POWERUP_CYCLES(50)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .touch_present(touch_present),
        .sample(sample), .tx_line(tx_line), .dsr_line(dsr_line), .cts_line(cts_line),
        .report_active(report_active));
    host_serial_rx host_u (.ref_clk(ref_clk), .line(tx_line), .rx_byte(rx_byte),
        .rx_count(rx_count), .frame_err(frame_err));
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 1200000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        exp_bytes = '{`HDR0_BYTE, `HDR1_BYTE, 8'h81, 8'hA5, 8'h0F, 8'h3C, 8'h5A, 8'h00, 8'h00,
            `CHK_SEED};
        for (int k = 0; k < 9; k++) exp_bytes[9] = exp_bytes[9] + exp_bytes[k];
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        touch_present <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check_bit(dsr_line, 1'b1);
        check_bit(cts_line, 1'b0);
        check_bit(report_active, 1'b0);
        for (int i = 0; i < 100 && report_active !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        check_bit(cts_line, 1'b1);
        check_bit(report_active, 1'b1);
        @(posedge ref_clk);
        sample <= {8'hFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
        touch_present <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            wait (rx_count == k + 1);
            check_byte(rx_byte, exp_bytes[k]);
            if (k == 3) begin
                // A short freeze in mid-packet must only stretch the stop bit.
                @(posedge ref_clk);
                clk_en <= 1'b0;
                repeat (20) @(posedge ref_clk);
                clk_en <= 1'b1;
            end
        end
        check_bit(frame_err, 1'b0);
        repeat (8000) @(posedge ref_clk);
        #1;
        check_bit(tx_line, 1'b1);
        check_byte(rx_count[7:0], 8'h0A);
        repeat (60000) @(posedge ref_clk);
        #1;
        check_bit(report_active, 1'b0);
        check_byte(rx_count[7:0], 8'h0A);
        tally_and_finish();
    end
endmodule
